// >>> rtl/lt_regs.svh
`ifndef LT_REGS_SVH
`define LT_REGS_SVH
// Tile shape
`define LT_SLICES     4
`define LT_LUT_BITS   16
`define LT_MEM_BITS   64
`define LT_SHIFT_MAX  8
`define LT_LOGIC_IN   20
`define LT_CTRL_IN    37
`define LT_SLICE_IN   5
`define LT_LINES      12
// Field positions inside the control input group
`define LT_CLK_LO     0
`define LT_CE_LO      12
`define LT_SR_LO      24
`define LT_SR_LINES   11
`define LT_CIN_BIT    35
`define LT_GSR_BIT    36
// Memory address fields inside the logic input group
`define LT_WA_LO      0
`define LT_WA_HI_LO   5
`define LT_RA_LO      10
`define LT_RA_HI_LO   15
// Reset values
`define LT_TRUTH_RST  64'h0
`endif

// >>> rtl/lt_pkg.sv
`include "lt_regs.svh"
package lt_pkg;
  // Per-slice operating mode
  typedef enum logic [1:0] {LT_COMB, LT_MEM, LT_SHIFT} lt_mode_t;
  // Distributed memory organisation, single and double port
  typedef enum logic [3:0] {
    LT_SP16X1, LT_SP16X2, LT_SP16X4, LT_SP32X1, LT_SP32X2, LT_SP64X1,
    LT_DP16X1, LT_DP16X2, LT_DP32X1
  } lt_org_t;
  // Source for a sequential element; only LT_SRC_WIDE takes the wide gate mux output
  typedef enum logic [2:0] {LT_SRC_LUT, LT_SRC_SUM, LT_SRC_WIDE, LT_SRC_FT_C, LT_SRC_FT_D, LT_SRC_FT_E} lt_src_t;

  typedef struct packed {
    lt_mode_t   mode;
    logic       ft_cd;         // Third/fourth inputs are feed-throughs
    logic       booth;         // AND gate feeds the carry cell
    logic       casc;          // Shift input from previous slice tap
    logic [2:0] shift_len_m1;  // Shift length minus one
    lt_src_t    src;
    logic       clk_sel;       // 0: primary tile clock, 1: second clock
    logic       clk_inv;       // Capture on falling edge
  } lt_slice_cfg_t;

  typedef struct packed {
    logic [3:0] primary_tile_clock_sel;
    logic [3:0] clk1_sel;
    logic [3:0] ce_sel;
    logic [3:0] sr_sel;
    logic       ce_use;
    lt_org_t    org;
    logic       mem_sync;
  } lt_tile_cfg_t;

  typedef struct packed {
    logic [`LT_MEM_BITS-1:0] truth;
    logic [1:0]              s1;
    logic [1:0]              s2;
    logic [1:0]              s3;
    logic [1:0]              lvl;
    logic [`LT_SLICES-1:0]   rd;
    logic [`LT_SLICES-1:0]   q;
    logic [`LT_SLICES-1:0]   comb;
    logic                    carry;
  } lt_state_t;
endpackage : lt_pkg

// >>> rtl/lt_logic_tile.sv
`timescale 1ns/1ps
`default_nettype none
`include "lt_regs.svh"

module lt_logic_tile
  import lt_pkg::*;
(
  input  wire logic                   i_core_clk,   // Core clock, 250 MHz
  input  wire logic                   i_rst,        // Synchronous reset, active high
  input  wire logic [`LT_LOGIC_IN-1:0] i_logic,     // Five logic inputs per slice
  input  wire logic [`LT_CTRL_IN-1:0] i_ctrl,       // Control lines from routing
  input  wire logic                   i_cfg_load,   // Load truth tables
  input  wire logic [`LT_MEM_BITS-1:0] i_cfg_truth, // Truth table image
  input  wire lt_tile_cfg_t           i_tile_cfg,   // Tile-wide configuration
  input  wire lt_slice_cfg_t [3:0]    i_slice_cfg,  // Per-slice configuration
  output logic [`LT_SLICES-1:0]       o_q,          // Sequential element outputs
  output logic [`LT_SLICES-1:0]       o_comb,       // Slice results, registered
  output logic                        o_carry       // Carry out of slice 0
);

  lt_state_t             st;
  lt_state_t             next_st;
  logic [1:0]            tclk;
  logic [1:0]            settle;
  logic [1:0]            rise;
  logic [1:0]            fall;
  logic                  ce;
  logic                  sr;
  logic                  cy;
  logic                  any_mem;
  logic                  dp;
  logic [2:0]            dl;
  logic [2:0]            wd;
  logic [5:0]            wa;
  logic [5:0]            ra;
  logic [5:0]            idx;
  logic [3:0]            addr;
  logic [3:0]            spo;
  logic [3:0]            dpo;
  logic [3:0]            memout;
  logic [3:0]            lutv;
  logic [3:0]            tap;
  logic [3:0]            res;
  logic [3:0]            sum;
  logic [3:0]            wide;
  logic [3:0]            dsel;
  logic [3:0]            edge_hit;
  logic [`LT_SLICE_IN-1:0] sin [4];

  // Pick one routing line; codes past the line count select a quiet zero
  function automatic logic line_sel(input logic [`LT_LINES-1:0] l, input logic [3:0] s);
    return (s < 4'(`LT_LINES)) ? l[s] : 1'b0;
  endfunction : line_sel

  // Flat bit position of word bit k at an address, for depth 2**dl
  function automatic logic [5:0] mem_idx(input logic [1:0] k, input logic [5:0] a, input logic [2:0] d);
    logic [5:0] m;
    m = 6'((7'h01 << d) - 7'h01);
    return 6'({4'h0, k} << d) | (a & m);
  endfunction : mem_idx

  ////////////////////////////////////////////////////////////////////////////
  // Control derivation and clock detection
  always_comb begin
    next_st = st;
    // Six controls: two tile clocks, enable, set/reset, carry in, global set/reset
    tclk[0] = line_sel(i_ctrl[`LT_CLK_LO +: `LT_LINES], i_tile_cfg.primary_tile_clock_sel);
    tclk[1] = line_sel(i_ctrl[`LT_CLK_LO +: `LT_LINES], i_tile_cfg.clk1_sel);
    ce = i_tile_cfg.ce_use ? line_sel(i_ctrl[`LT_CE_LO +: `LT_LINES], i_tile_cfg.ce_sel) : 1'b1;
    sr = line_sel({1'b0, i_ctrl[`LT_SR_LO +: `LT_SR_LINES]}, i_tile_cfg.sr_sel)
         | i_ctrl[`LT_GSR_BIT];
    // Tile clocks are fabric signals; a level counts once stages two and three agree
    next_st.s1 = tclk;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    settle = ~(st.s2 ^ st.s3);
    rise = settle & st.s2 & ~st.lvl;
    fall = settle & ~st.s2 & st.lvl;
    next_st.lvl = (settle & st.s2) | (~settle & st.lvl);

    ////////////////////////////////////////////////////////////////////////////
    // Memory organisation
    dl = 3'd4;
    wd = 3'd1;
    dp = 1'b0;
    unique case (i_tile_cfg.org)
      LT_SP16X1: begin dl = 3'd4; wd = 3'd1; end
      LT_SP16X2: begin dl = 3'd4; wd = 3'd2; end
      LT_SP16X4: begin dl = 3'd4; wd = 3'd4; end
      LT_SP32X1: begin dl = 3'd5; wd = 3'd1; end
      LT_SP32X2: begin dl = 3'd5; wd = 3'd2; end
      LT_SP64X1: begin dl = 3'd6; wd = 3'd1; end
      LT_DP16X1: begin dl = 3'd4; wd = 3'd1; dp = 1'b1; end
      LT_DP16X2: begin dl = 3'd4; wd = 3'd2; dp = 1'b1; end
      LT_DP32X1: begin dl = 3'd5; wd = 3'd1; dp = 1'b1; end
      default:   begin dl = 3'd4; wd = 3'd1; end
    endcase
    // Write/read address from slice 0/1 inputs, second read port from slice 2/3
    wa = {i_logic[`LT_WA_HI_LO +: 2], i_logic[`LT_WA_LO +: 4]};
    ra = {i_logic[`LT_RA_HI_LO +: 2], i_logic[`LT_RA_LO +: 4]};
    any_mem = 1'b0;
    for (int i = 0; i < `LT_SLICES; i++) begin
      sin[i] = i_logic[i*`LT_SLICE_IN +: `LT_SLICE_IN];
      any_mem = any_mem | (i_slice_cfg[i].mode == LT_MEM);
    end
    // Read ports, word bit k lands on slice k, second port on slices 2 and 3
    for (int k = 0; k < `LT_SLICES; k++) begin
      spo[k] = (3'(k) < wd) ? st.truth[mem_idx(2'(k), wa, dl)] : 1'b0;
      dpo[k] = (3'(k) < wd) ? st.truth[mem_idx(2'(k), ra, dl)] : 1'b0;
    end
    for (int i = 0; i < `LT_SLICES; i++) begin
      memout[i] = (dp && i >= 2) ? dpo[i % 2] : spo[i];
      if (i_tile_cfg.mem_sync) begin
        memout[i] = st.rd[i]; // Sync read trades a clock of latency for timing
      end
    end
    if (rise[0]) begin
      for (int i = 0; i < `LT_SLICES; i++) begin
        next_st.rd[i] = (dp && i >= 2) ? dpo[i % 2] : spo[i];
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slice logic: LUT, shift taps, result select
    for (int i = 0; i < `LT_SLICES; i++) begin
      // Two dedicated LUT inputs; third and fourth may be feed-throughs
      addr = {i_slice_cfg[i].ft_cd ? 2'b00 : sin[i][3:2], sin[i][1:0]};
      lutv[i] = st.truth[i*`LT_LUT_BITS + int'(addr)];
      tap[i] = st.truth[i*`LT_LUT_BITS + int'(i_slice_cfg[i].shift_len_m1)];
      unique case (i_slice_cfg[i].mode)
        LT_COMB:  res[i] = lutv[i];
        LT_MEM:   res[i] = memout[i];
        LT_SHIFT: res[i] = tap[i];
        default:  res[i] = 1'b0;
      endcase
    end

    // Carry ripples from slice 3 down to slice 0
    cy = i_ctrl[`LT_CIN_BIT];
    for (int i = `LT_SLICES - 1; i >= 0; i--) begin
      dsel[i] = i_slice_cfg[i].booth ? (sin[i][0] & sin[i][1]) : sin[i][2];
      sum[i] = res[i] ^ dsel[i] ^ cy;
      cy = (res[i] & dsel[i]) | (cy & (res[i] ^ dsel[i]));
    end
    next_st.carry = cy;

    // Wide gate mux sits between slices and elements; fifth input selects
    for (int i = 0; i < `LT_SLICES; i++) begin
      wide[i] = sin[i][4] ? res[i ^ 1] : res[i];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift registers clock on the primary tile clock with enable
    if (rise[0] && ce) begin
      for (int i = 0; i < `LT_SLICES; i++) begin
        if (i_slice_cfg[i].mode == LT_SHIFT) begin
          next_st.truth[i*`LT_LUT_BITS +: `LT_SHIFT_MAX] =
            {st.truth[i*`LT_LUT_BITS +: `LT_SHIFT_MAX-1],
             (i > 0 && i_slice_cfg[i].casc) ? tap[(i+3)%4] : sin[i][4]};
        end
      end
    end

    // Memory write: strobe is the set/reset line, clocked by the primary clock
    idx = 6'h0; // Default keeps the index from latching
    if (any_mem && sr && rise[0]) begin
      for (int k = 0; k < `LT_SLICES; k++) begin
        idx = mem_idx(2'(k), wa, dl);
        // Only bits owned by a memory-mode slice may change
        if (3'(k) < wd && i_slice_cfg[idx[5:4]].mode == LT_MEM) begin
          next_st.truth[idx] = sin[k][4];
        end
      end
    end

    // Configuration load overrides any same-cycle update
    if (i_cfg_load) begin
      next_st.truth = i_cfg_truth;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequential elements
    for (int i = 0; i < `LT_SLICES; i++) begin
      edge_hit[i] = i_slice_cfg[i].clk_inv ? fall[i_slice_cfg[i].clk_sel] : rise[i_slice_cfg[i].clk_sel];
      // In memory mode set/reset is the write strobe, so it no longer clears
      if (edge_hit[i] && sr && !any_mem) begin
        next_st.q[i] = 1'b0;
      end else if (edge_hit[i] && ce) begin
        unique case (i_slice_cfg[i].src)
          LT_SRC_LUT:  next_st.q[i] = res[i];
          LT_SRC_SUM:  next_st.q[i] = sum[i];
          LT_SRC_WIDE: next_st.q[i] = wide[i];
          LT_SRC_FT_C: next_st.q[i] = sin[i][2];
          LT_SRC_FT_D: next_st.q[i] = sin[i][3];
          LT_SRC_FT_E: next_st.q[i] = sin[i][4];
          default:     next_st.q[i] = st.q[i];
        endcase
      end
    end
    next_st.comb = res;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st       <= '0;
      st.truth <= `LT_TRUTH_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign o_q     = st.q;
  assign o_comb  = st.comb;
  assign o_carry = st.carry;

endmodule : lt_logic_tile
`default_nettype wire

// >>> bench/lt_tile_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "lt_regs.svh"
module lt_tile_checker
  import lt_pkg::*;
(
  input wire logic                    i_core_clk,  // Core clock
  input wire logic                    i_rst,       // Sync reset
  input wire logic [`LT_LOGIC_IN-1:0] i_logic,     // Slice inputs
  input wire logic [`LT_CTRL_IN-1:0]  i_ctrl,      // Control lines
  input wire logic                    i_cfg_load,  // Truth load
  input wire logic [`LT_MEM_BITS-1:0] i_cfg_truth, // Truth image
  input wire lt_tile_cfg_t            i_tile_cfg,  // Tile setup
  input wire lt_slice_cfg_t [3:0]     i_slice_cfg, // Slice setup
  input wire logic [`LT_SLICES-1:0]   o_q,         // Elements
  input wire logic [`LT_SLICES-1:0]   o_comb,      // Results
  input wire logic                    o_carry      // Carry out
);
  logic [63:0] shadow;
  logic [36:0] prev;
  logic [2:0]  still;
  logic [3:0]  exp_res, all_comb, boo;
  logic        ok, cy, op;
  wire         chk_ok = ok && (&all_comb);
  // Lookup and carry reference, slice 3 feeds the chain first
  always_comb begin
    cy = i_ctrl[`LT_CIN_BIT];
    op = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      exp_res[i] = shadow[16*i+i_logic[5*i+:4]];
      op = i_slice_cfg[i].booth ? i_logic[5*i] & i_logic[5*i+1] : i_logic[5*i+2];
      cy = (exp_res[i] & op) | (exp_res[i] & cy) | (op & cy);
      all_comb[i] = i_slice_cfg[i].mode == LT_COMB && !i_slice_cfg[i].ft_cd;
      boo[i] = i_slice_cfg[i].booth;
    end
  end
  // Truth copy is trusted from reset or after a load, while every slice stays combinational
  always_ff @(posedge i_core_clk) begin
    prev <= i_ctrl;
    if (i_rst) begin
      shadow <= 64'h0;
      ok <= 1'b1;
      still <= 3'h0;
    end else begin
      if (i_cfg_load) begin
        shadow <= i_cfg_truth;
      end
      ok <= (ok | i_cfg_load) & (&all_comb);
      still <= (i_ctrl != prev) ? 3'h0 : still + {2'h0, still != 3'h7};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_rst_out_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $past(i_rst) |-> o_q == 4'h0 && o_comb == 4'h0 && !o_carry) else $error("outputs not clear after reset");
  a_lut_slice0: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rst) && $past(chk_ok) |-> o_comb[0] == $past(exp_res[0])) else $error("slice 0 lookup wrong");
  a_lut_slice1: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rst) && $past(chk_ok) |-> o_comb[1] == $past(exp_res[1])) else $error("slice 1 lookup wrong");
  a_lut_upper: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rst) && $past(chk_ok) |-> o_comb[3:2] == $past(exp_res[3:2])) else $error("upper lookup wrong");
  a_carry_plain: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rst) && $past(chk_ok) && $past(boo) == 4'h0 |-> o_carry == $past(cy)) else $error("carry wrong");
  a_carry_booth: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rst) && $past(chk_ok) && $past(boo) == 4'hf |-> o_carry == $past(cy)) else $error("booth carry wrong");
  a_q_hold_still: assert property (@(posedge i_core_clk) disable iff (i_rst)
    still >= 3'h5 |-> $stable(o_q)) else $error("element moved without control change");
  // A capture in memory mode must take the slice result, never a strobe-driven clear
  a_mem_keep_q: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_slice_cfg[0].mode == LT_MEM && i_slice_cfg[0].src == LT_SRC_LUT && $changed(o_q[0])
    |-> o_q[0] == o_comb[0]) else $error("strobe disturbed elements in memory mode");
endmodule : lt_tile_checker
bind lt_logic_tile lt_tile_checker u_lt_tile_checker (.i_core_clk, .i_rst, .i_logic, .i_ctrl, .i_cfg_load,
  .i_cfg_truth, .i_tile_cfg, .i_slice_cfg, .o_q, .o_comb, .o_carry);
`default_nettype wire

// >>> bench/lt_route_model.sv
`timescale 1ns/1ps
`default_nettype none
module lt_route_model (
  input  wire logic i_core_clk, // Core clock
  input  wire logic i_rst,      // Sync reset
  input  wire logic i_fire,     // Request one tile clock pulse
  input  wire logic i_we,       // Hold write strobe over the pulse
  output logic      o_line_clk, // Primary tile clock line
  output logic      o_sr        // Set/reset line, write strobe
);
  logic [3:0] cnt;
  // Six cycles high, six low, so edges clear the three-flop synchroniser
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt <= 4'h0;
      o_sr <= 1'b0;
    end else if (i_fire && cnt == 4'h0) begin
      cnt <= 4'hc;
      o_sr <= i_we;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      o_sr <= o_sr && cnt != 4'h1;
    end
  end
  // Line idles low between pulses
  assign o_line_clk = cnt > 4'h6;
endmodule : lt_route_model
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import lt_pkg::*;
;
  logic                clk = 1'b0, rst = 1'b1, load = 1'b0, fire = 1'b0, we = 1'b0, ce = 1'b0, cin = 1'b0;
  logic                line, sr, carry;
  logic [3:0]          q, comb;
  logic [19:0]         lg = 20'h0;
  logic [63:0]         truth = 64'h0;
  lt_tile_cfg_t        tc = '0;
  lt_slice_cfg_t [3:0] sc = '0;
  int                  err_total = 0, n_compared = 0;
  // Core clock, 4 ns period
  always #2 clk = ~clk;
  lt_logic_tile u_lt_logic_tile (.i_core_clk(clk), .i_rst(rst), .i_logic(lg), .i_cfg_load(load),
    .i_ctrl({1'b0, cin, 10'h0, sr, 11'h0, ce, 11'h0, line}), .i_cfg_truth(truth), .i_tile_cfg(tc),
    .i_slice_cfg(sc), .o_q(q), .o_comb(comb), .o_carry(carry));
  lt_route_model u_lt_route_model (.i_core_clk(clk), .i_rst(rst), .i_fire(fire), .i_we(we),
    .o_line_clk(line), .o_sr(sr));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Whole pulse plus both detected edges, so the next one is legally spaced
  task automatic pulse(input logic w);
    fire = 1'b1;
    we = w;
    cyc(1);
    fire = 1'b0;
    cyc(14);
  endtask : pulse
  task automatic ld(input logic [63:0] t);
    truth = t;
    load = 1'b1;
    cyc(1);
    load = 1'b0;
    cyc(1);
  endtask : ld
  task automatic t_comb;
    ld(64'h6996_00ff_8001_a5c3);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 16; k++) begin
        lg = {4{1'b0, 4'(k)}};
        cyc(2);
        for (int i = 0; i < 4; i++) chk(comb[i], truth[16*i+k]);
      end
      for (int i = 0; i < 4; i++) sc[i].booth = 1'b1;
      cin = 1'b1;
    end
    lg = 20'h0;
    pulse(1'b0);
    chk(q, 4'h7);
    $display("comb test done");
  endtask : t_comb
  // Feed-throughs bypass the LUT; slice 3 takes its neighbour through the wide mux
  task automatic t_feed;
    sc = '0;
    sc[0].src = LT_SRC_FT_C;
    sc[0].ft_cd = 1'b1;
    sc[1].src = LT_SRC_FT_D;
    sc[1].ft_cd = 1'b1;
    sc[2].src = LT_SRC_FT_E;
    sc[3].src = LT_SRC_WIDE;
    ld(64'h0000_0001_0000_0010);
    lg = 20'h84104;
    pulse(1'b0);
    chk(comb[0], 1'b0);
    chk(q[2:0], 3'h7);
    chk(q[3], 1'b1);
    $display("feed test done");
  endtask : t_feed
  task automatic t_mem;
    // Every organisation: write a one at word 0, read it back asynchronously
    for (int o = 0; o < 9; o++) begin
      for (int i = 0; i < 4; i++) sc[i] = '{mode: LT_MEM, src: LT_SRC_LUT, default: '0};
      tc.org = lt_org_t'(o);
      lg = 20'h10;
      ld(64'h0);
      pulse(1'b1);
      chk(comb[0], 1'b1);
    end
    sc = '0;
    sc[0].mode = LT_MEM;
    tc.org = LT_SP16X2;
    lg = 20'h2b5;
    ld(64'h0);
    pulse(1'b0);
    chk(comb[0], 1'b0);
    pulse(1'b1);
    chk(comb[0], 1'b1);
    chk(comb[1], 1'b0);
    // Sync read shows the word as it stood at the edge, before that edge's write
    tc.mem_sync = 1'b1;
    lg = 20'h2a5;
    pulse(1'b1);
    chk(comb[0], 1'b1);
    pulse(1'b1);
    chk(comb[0], 1'b0);
    chk(q[0], 1'b1);
    tc.mem_sync = 1'b0;
    $display("memory test done");
  endtask : t_mem
  task automatic t_shift;
    for (int i = 0; i < 4; i++) begin
      sc[i] = '{mode: LT_SHIFT, src: LT_SRC_LUT, shift_len_m1: 3'h7, casc: i != 0, default: '0};
    end
    ld(64'h0);
    ce = 1'b1;
    for (int n = 1; n <= 32; n++) begin
      lg = (n == 1) ? 20'h11 : 20'h0;
      pulse(1'b0);
      chk(comb[0], n == 8);
      chk(comb[3], n == 32);
    end
    ce = 1'b0;
    $display("shift test done");
  endtask : t_shift
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // Main sequence; a second reset at the end clears shift contents
  initial begin
    cyc(3);
    rst = 1'b0;
    cyc(1);
    chk({q, comb, carry}, 9'h0);
    t_comb;
    t_feed;
    t_mem;
    t_shift;
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    cyc(1);
    chk({q, comb, carry}, 9'h0);
    finish_test;
  end
  // Watchdog well beyond the expected run of about 800 cycles
  initial begin
    #20000;
    err_total++;
    finish_test;
  end
endmodule : tb
`default_nettype wire
